/* inc/hgio_defs.vh */
`ifndef HGIO_DEFS_VH
`define HGIO_DEFS_VH

// register indices; byte address is four times the index
`define HGIO_IDX_RX_PORT_CTL 8'h0C
`define HGIO_IDX_IO_VOLT 8'h0D
`define HGIO_IDX_PIN_STS 8'h0E
`define HGIO_IDX_INPUT_EN 8'h0F
`define HGIO_IDX_PIN0_CTL 8'h10

// io_voltage_control fields
`define HGIO_IO_SEL_BIT 7
`define HGIO_IO_OVR_BIT 6
`define HGIO_IO_MODE_HI 5
`define HGIO_IO_MODE_LO 4
`define HGIO_IO_RSVD 4'h9
`define HGIO_MODE_1V8 2'h0
`define HGIO_MODE_3V3 2'h3

// pin0_output_control fields
`define HGIO_SEL_HI 7
`define HGIO_SEL_LO 5
`define HGIO_SRC_HI 4
`define HGIO_SRC_LO 2
`define HGIO_VAL_BIT 1
`define HGIO_OEN_BIT 0

// reset values
`define HGIO_RST_IO_VOLT 4'h0
`define HGIO_RST_INPUT_EN 8'hFF
`define HGIO_RST_PIN0_CTL 8'h00
`define HGIO_RST_RX_EN 4'hF

// source codes
`define HGIO_SRC_STATUS 3'h4
`define HGIO_SRC_RSVD 3'h5
`define HGIO_SRC_TX0 3'h6
`define HGIO_SRC_TX1 3'h7

`endif

/* src/hgio_pin_mux.v */
`include "hgio_defs.vh"

module hgio_pin_mux (
    // control
    input wire [2:0] src,
    input wire [2:0] sel,
    input wire out_val,
    input wire [3:0] rx_en,
    // receive port status
    input wire [15:0] rx_remote_pins,
    input wire [3:0] rx_lock,
    input wire [3:0] rx_pass,
    input wire [3:0] rx_frame_valid,
    input wire [3:0] rx_line_valid,
    input wire frame_sync_pulse,
    // transmit port status
    input wire [1:0] tx_pass_and,
    input wire [1:0] tx_pass_or,
    input wire [1:0] tx_frame_valid,
    input wire [1:0] tx_line_valid,
    input wire [1:0] tx_synced,
    input wire [1:0] tx_irq,
    // result
    output reg level
);

    wire [1:0] rx_idx = src[1:0];
    wire tx_idx = src[0];
    // disabled ports drop out of the combinations; none enabled gives or=0, and=1
    wire any_lock = |(rx_lock & rx_en);
    wire all_lock = &(rx_lock | ~rx_en);
    wire all_pass = &(rx_pass | ~rx_en);

    always @* begin
        level = 1'b0;
        if (src[2] == 1'b0) begin
            case (sel)
                3'h0, 3'h1, 3'h2, 3'h3: level = rx_remote_pins[{rx_idx, sel[1:0]}];
                3'h4: level = rx_lock[rx_idx];
                3'h5: level = rx_pass[rx_idx];
                3'h6: level = rx_frame_valid[rx_idx];
                default: level = rx_line_valid[rx_idx];
            endcase
        end else if (src == `HGIO_SRC_STATUS) begin
            case (sel)
                3'h0: level = out_val;
                3'h1: level = any_lock;
                3'h2: level = all_lock;
                3'h3: level = all_pass;
                3'h4: level = frame_sync_pulse;
                default: level = 1'b0;
            endcase
        end else if (src == `HGIO_SRC_RSVD) begin
            level = 1'b0;
        end else begin
            case (sel)
                3'h0: level = tx_pass_and[tx_idx];
                3'h1: level = tx_pass_or[tx_idx];
                3'h2: level = tx_frame_valid[tx_idx];
                3'h3: level = tx_line_valid[tx_idx];
                3'h4: level = tx_synced[tx_idx];
                3'h5: level = tx_irq[tx_idx];
                default: level = 1'b0;
            endcase
        end
    end

endmodule // hgio_pin_mux

/* src/hgio_top.v */
// Notes on behaviour
// - bit 7 of the io control register picks 1.8V (0) or 3.3V (1) signalling.
// - with override clear, select bit and supply mode follow the detected level.
// - with override set, the software-written select bit and mode field apply.
// - with override clear, reads return the detected level, mode 00=1.8V, 11=3.3V.
// - a read-only byte returns the present level of all eight pins, bit n for pin n.
// - one input enable per pin, 0 disables, 1 enables, all reset to 1.
// - pin 0 source field 4:2 picks rx port 0-3, device status, reserved, tx 0 or tx 1.
// - for an rx source, select picks remote pins 0-3, lock, pass, frame or line valid.
// - for device status, select picks out value, or-lock, and-lock, and-pass, frame sync.
// - for a tx source, select picks and-pass, or-pass, frame, line, synced, interrupt.
// - pin 0 is driven only while its enable bit is 1; the source and select fields pick the level.
// - an rx port counts for the lock and pass combinations while its enable bit is 1.
`include "hgio_defs.vh"

module hgio_top (
    // clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // avalon-mm slave
    input wire [7:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    // voltage detect and control
    input wire io_level_detect_3v3,
    output wire high_voltage_select,
    output wire [1:0] io_supply_mode,
    // general pins
    input wire [7:0] pin_in,
    output wire [7:0] pin_input_enable,
    output reg pin0_out,
    output reg pin0_oe,
    // receive port status
    input wire [15:0] rx_remote_pins,
    input wire [3:0] rx_lock,
    input wire [3:0] rx_pass,
    input wire [3:0] rx_frame_valid,
    input wire [3:0] rx_line_valid,
    output wire [3:0] rx_port_receiver_enable,
    input wire frame_sync_pulse,
    // transmit port status
    input wire [1:0] tx_pass_and,
    input wire [1:0] tx_pass_or,
    input wire [1:0] tx_frame_valid,
    input wire [1:0] tx_line_valid,
    input wire [1:0] tx_synced,
    input wire [1:0] tx_irq
);

    reg [3:0] io_volt_reg;
    reg [7:0] input_en_reg;
    reg [7:0] pin0_ctl_reg;
    reg [3:0] rx_en_reg;
    reg [7:0] pin_meta_reg;
    reg [7:0] pin_sync_reg;
    reg det_meta_reg;
    reg det_sync_reg;
    reg ack_reg;
    reg [31:0] rd_next;
    wire mux_level;

    function [7:0] hgio_byte_index;
        input [7:0] byte_addr;
        begin
            hgio_byte_index = {2'b00, byte_addr[7:2]};
        end
    endfunction

    wire [7:0] idx = hgio_byte_index(avs_address);
    wire access = avs_read | avs_write;
    // one wait state per access; read data registered in the wait cycle
    assign avs_waitrequest = access & ~ack_reg;
    // a write lands only on the edge where waitrequest is seen low
    wire wr_go = avs_write & ack_reg & avs_byteenable[0];

    // pins and detect come from outside the clock domain
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            pin_meta_reg <= 8'h00;
            pin_sync_reg <= 8'h00;
            det_meta_reg <= 1'b0;
            det_sync_reg <= 1'b0;
        end else begin
            pin_meta_reg <= pin_in;
            pin_sync_reg <= pin_meta_reg;
            det_meta_reg <= io_level_detect_3v3;
            det_sync_reg <= det_meta_reg;
        end
    end

    wire ovr = io_volt_reg[2];
    // io_volt_reg holds {sel, ovr, mode[1:0]} = bits 7:4
    assign high_voltage_select = ovr ? io_volt_reg[3] : det_sync_reg;
    assign io_supply_mode = ovr ? io_volt_reg[1:0] :
        (det_sync_reg ? `HGIO_MODE_3V3 : `HGIO_MODE_1V8);
    assign pin_input_enable = input_en_reg;
    assign rx_port_receiver_enable = rx_en_reg;

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            io_volt_reg <= `HGIO_RST_IO_VOLT;
            input_en_reg <= `HGIO_RST_INPUT_EN;
            pin0_ctl_reg <= `HGIO_RST_PIN0_CTL;
            rx_en_reg <= `HGIO_RST_RX_EN;
            ack_reg <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack_reg <= access & ~ack_reg;
            if (avs_read & ~ack_reg) begin
                avs_readdata <= rd_next;
            end
            if (wr_go) begin
                if (idx == `HGIO_IDX_IO_VOLT) begin
                    io_volt_reg <= avs_writedata[7:4];
                end else if (idx == `HGIO_IDX_INPUT_EN) begin
                    input_en_reg <= avs_writedata[7:0];
                end else if (idx == `HGIO_IDX_PIN0_CTL) begin
                    pin0_ctl_reg <= avs_writedata[7:0];
                end else if (idx == `HGIO_IDX_RX_PORT_CTL) begin
                    rx_en_reg <= avs_writedata[3:0];
                end
            end
        end
    end

    // unmapped addresses read zero and ignore writes
    always @* begin
        rd_next = 32'h0000_0000;
        if (idx == `HGIO_IDX_IO_VOLT) begin
            rd_next[7:0] = {high_voltage_select, ovr, io_supply_mode, `HGIO_IO_RSVD};
        end else if (idx == `HGIO_IDX_PIN_STS) begin
            rd_next[7:0] = pin_sync_reg;
        end else if (idx == `HGIO_IDX_INPUT_EN) begin
            rd_next[7:0] = input_en_reg;
        end else if (idx == `HGIO_IDX_PIN0_CTL) begin
            rd_next[7:0] = pin0_ctl_reg;
        end else if (idx == `HGIO_IDX_RX_PORT_CTL) begin
            rd_next[7:0] = {4'h0, rx_en_reg};
        end
    end

    hgio_pin_mux u_mux (
        .src(pin0_ctl_reg[`HGIO_SRC_HI:`HGIO_SRC_LO]),
        .sel(pin0_ctl_reg[`HGIO_SEL_HI:`HGIO_SEL_LO]),
        .out_val(pin0_ctl_reg[`HGIO_VAL_BIT]),
        .rx_en(rx_en_reg),
        .rx_remote_pins(rx_remote_pins),
        .rx_lock(rx_lock),
        .rx_pass(rx_pass),
        .rx_frame_valid(rx_frame_valid),
        .rx_line_valid(rx_line_valid),
        .frame_sync_pulse(frame_sync_pulse),
        .tx_pass_and(tx_pass_and),
        .tx_pass_or(tx_pass_or),
        .tx_frame_valid(tx_frame_valid),
        .tx_line_valid(tx_line_valid),
        .tx_synced(tx_synced),
        .tx_irq(tx_irq),
        .level(mux_level)
    );

    // registered pin drive: one cycle of latency, no glitches on the pad
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            pin0_out <= 1'b0;
            pin0_oe <= 1'b0;
        end else begin
            pin0_oe <= pin0_ctl_reg[`HGIO_OEN_BIT];
            pin0_out <= mux_level;
        end
    end

endmodule // hgio_top

/* dv/hgio_top_sva.sv */
module hgio_top_chk (
    // clock, reset and bus
    input wire logic clk_sys, sys_rst, avs_read, avs_write, avs_waitrequest,
    input wire logic [7:0] avs_address,
    input wire logic [31:0] avs_writedata, avs_readdata,
    input wire logic [3:0] avs_byteenable,
    // pins and controls
    input wire logic io_level_detect_3v3, high_voltage_select, pin0_oe,
    input wire logic [1:0] io_supply_mode,
    input wire logic [7:0] pin_input_enable,
    input wire logic [3:0] rx_port_receiver_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic ovr_reg, sel_reg;
    logic [1:0] mode_reg;
    wire acc_wr = avs_write && !avs_waitrequest && avs_byteenable[0];
    // shadow of the override state, so the select outputs can be judged
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            ovr_reg <= 1'b0;
            sel_reg <= 1'b0;
            mode_reg <= 2'b00;
        end else if (acc_wr && avs_address == 8'h34) begin
            ovr_reg <= avs_writedata[6];
            sel_reg <= avs_writedata[7];
            mode_reg <= avs_writedata[5:4];
        end
    end
    chk_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=>
        !avs_waitrequest) else $error("no answer after one wait state");
    chk_read_upper: assert property (avs_read && !avs_waitrequest |->
        avs_readdata[31:8] == 24'h00_0000) else $error("upper read bits set");
    // three stable cycles cover the two-stage synchroniser
    chk_sel_detect: assert property ((!ovr_reg && $stable(io_level_detect_3v3))[*3] |->
        high_voltage_select == io_level_detect_3v3) else $error("select ignores detect");
    chk_mode_detect: assert property ((!ovr_reg && $stable(io_level_detect_3v3))[*3] |->
        io_supply_mode == {2{io_level_detect_3v3}}) else $error("mode ignores detect");
    chk_sel_override: assert property (ovr_reg |-> high_voltage_select == sel_reg &&
        io_supply_mode == mode_reg) else $error("override values not applied");
    chk_oe_reset: assert property ($fell(sys_rst) |-> !pin0_oe)
        else $error("pin driven after reset");
    chk_oe_write: assert property (acc_wr && avs_address == 8'h40 |-> ##2
        pin0_oe == $past(avs_writedata[0], 2)) else $error("enable not applied");
    chk_inen_reset: assert property ($fell(sys_rst) |-> pin_input_enable == 8'hFF)
        else $error("input enables not set");
    chk_inen_write: assert property (acc_wr && avs_address == 8'h3C |=>
        pin_input_enable == $past(avs_writedata[7:0])) else $error("input enables stale");
    chk_rxen_reset: assert property ($fell(sys_rst) |-> rx_port_receiver_enable == 4'hF)
        else $error("receiver enables not set");
endmodule // hgio_top_chk
bind hgio_top hgio_top_chk i_chk (.clk_sys, .sys_rst, .avs_read, .avs_write, .avs_waitrequest,
    .avs_address, .avs_writedata, .avs_readdata, .avs_byteenable, .io_level_detect_3v3,
    .high_voltage_select, .pin0_oe, .io_supply_mode, .pin_input_enable, .rx_port_receiver_enable);

/* dv/hgio_board.sv */
module hgio_board (
    // pin 0 drive and board levels
    input wire logic pin0_out, pin0_oe,
    input wire logic [7:0] ext,
    output logic [7:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // pin 0 reads back the device drive while enabled, else the board level
    assign pin_in = {ext[7:1], pin0_oe ? pin0_out : ext[0]};
endmodule // hgio_board

/* dv/hub_gpio_and_io_level_control_bench.sv */
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
    $display("Error at %0t: got %h want %h", $time, g, e); end end
module hub_gpio_and_io_level_control_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 0, sys_rst = 1, avs_read = 0, avs_write = 0, det = 0, frame_sync_pulse = 0;
    logic [7:0] avs_address = 0, ext = 0, q, pin_in, pin_input_enable;
    logic [31:0] avs_writedata = 0, avs_readdata;
    logic [15:0] rx_remote_pins = 0;
    logic [3:0] rx_lock = 0, rx_pass = 0, rx_frame_valid = 0, rx_line_valid = 0, ren, rxe;
    logic [1:0] tx_pass_and = 0, tx_pass_or = 0, tx_frame_valid = 0, tx_line_valid = 0;
    logic [1:0] tx_synced = 0, tx_irq = 0, mode;
    logic avs_waitrequest, hvs, pin0_out, pin0_oe, out_bit;
    logic [3:0] avs_byteenable = 4'hF;
    int bad_count = 0, cmp_count = 0;
    always #50 clk_sys = ~clk_sys;
    hgio_top i_dut (.clk_sys, .sys_rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .io_level_detect_3v3(det),
        .high_voltage_select(hvs), .io_supply_mode(mode), .pin_in, .pin_input_enable,
        .pin0_out, .pin0_oe, .rx_remote_pins, .rx_lock, .rx_pass, .rx_frame_valid, .rx_line_valid,
        .rx_port_receiver_enable(rxe), .frame_sync_pulse, .tx_pass_and, .tx_pass_or,
        .tx_frame_valid, .tx_line_valid, .tx_synced, .tx_irq);
    hgio_board i_board (.pin0_out, .pin0_oe, .ext, .pin_in);
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic print_verdict;
        $display("mismatches %0d comparisons %0d", bad_count, cmp_count);
        if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // one access: hold until waitrequest low, then release and let an edge pass
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_read <= !w;
        avs_write <= w;
        do begin @(posedge clk_sys); n++; end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata[7:0];
        avs_read <= 0;
        avs_write <= 0;
        @(posedge clk_sys);
        if (n >= 20) begin bad_count++; print_verdict; end
    endtask
    function automatic logic expv(input logic [2:0] s, input logic [2:0] c, input logic v);
        logic [7:0] w;
        if (!s[2]) w = {rx_line_valid[s], rx_frame_valid[s], rx_pass[s], rx_lock[s],
            rx_remote_pins[s*4+:4]};
        else if (s[1]) w = {2'b00, tx_irq[s[0]], tx_synced[s[0]], tx_line_valid[s[0]],
            tx_frame_valid[s[0]], tx_pass_or[s[0]], tx_pass_and[s[0]]};
        else if (s[0]) w = 8'h00;
        else w = {3'b000, frame_sync_pulse, &(rx_pass | ~ren), &(rx_lock | ~ren),
            |(rx_lock & ren), v};
        return w[c];
    endfunction
    task automatic t_reset;
        acc(0, 8'h34, 0); `CHK(q, 8'h09)
        acc(0, 8'h3C, 0); `CHK(q, 8'hFF)
        acc(0, 8'h30, 0); `CHK(q[3:0], 4'hF)
        acc(0, 8'h40, 0); `CHK({q, pin0_oe}, 9'h000)
    endtask
    task automatic t_volt;
        det <= 1; idle(4); acc(0, 8'h34, 0); `CHK({q, hvs, mode}, 11'h5CF)
        acc(1, 8'h34, 8'h40); acc(0, 8'h34, 0); `CHK({q, hvs, mode}, 11'h248)
        acc(1, 8'h34, 8'hF0); det <= 0; idle(4); acc(0, 8'h34, 0);
        `CHK({q, hvs, mode}, 11'h7CF)
        acc(1, 8'h34, 8'h80); acc(0, 8'h34, 0); `CHK({q, hvs, mode}, 11'h048)
    endtask
    task automatic t_pins;
        ext <= 8'hA5; idle(3); acc(0, 8'h38, 0); `CHK(q, 8'hA5)
        ext <= 8'h5A; idle(3); acc(0, 8'h38, 0); `CHK(q, 8'h5A)
        acc(1, 8'h3C, 8'h81); acc(1, 8'h80, 8'hFF); acc(0, 8'h80, 0); `CHK(q, 8'h00)
        // a write with lane 0 disabled must leave the enables alone
        avs_byteenable <= 4'hE;
        acc(1, 8'h3C, 8'h00);
        avs_byteenable <= 4'hF;
        acc(0, 8'h3C, 0); `CHK({q, pin_input_enable}, 16'h8181)
    endtask
    task automatic t_mux;
        for (int k = 0; k < 2; k++) begin
            {rx_remote_pins, rx_lock, rx_pass, rx_frame_valid, rx_line_valid} <=
                k ? ~32'h5A3C_6E29 : 32'h5A3C_6E29;
            {tx_pass_and, tx_pass_or, tx_frame_valid, tx_line_valid, tx_synced, tx_irq} <=
                k ? ~12'h09C6 : 12'h09C6;
            frame_sync_pulse <= k[0];
            ren = k ? 4'h1 : 4'hF;
            acc(1, 8'h30, {4'h0, ren}); `CHK(rxe, ren)
            for (int s = 0; s < 8; s++) for (int c = 0; c < 8; c++) begin
                // value bit flips with k so the register-value select sees both levels
                out_bit = k[0] ^ s[0] ^ c[0];
                acc(1, 8'h40, {c[2:0], s[2:0], out_bit, 1'b1});
                idle(1);
                `CHK(pin0_oe, 1'b1)
                `CHK(pin0_out, expv(s[2:0], c[2:0], out_bit))
            end
        end
        acc(1, 8'h40, 8'h02); idle(1); `CHK(pin0_oe, 1'b0)
    endtask
    initial begin
        idle(16);
        sys_rst <= 0;
        idle(1);
        t_reset;
        t_volt;
        t_pins;
        t_mux;
        print_verdict;
    end
endmodule // hub_gpio_and_io_level_control_bench
